// ===== core/temp_monitor_alarm_logic.sv
// Control logic of a dual-channel temperature monitor: serial bus slave, limits and alarm outputs
// Summary of operation
// - First written byte loads register pointer
// - Second written byte goes to pointed register
// - Read returns register at current pointer
// - Alarm low when out of limits or open
// - Answer alert response with own address, LSB one
// - Bus arbitration decides between alert responders
// - Release alarm after response if condition cleared
// - Standby bit stops and abandons periodic conversions
// - Serial bus works fully in standby
// - Trigger write starts one conversion, any data
// - New limits compared against stored values immediately
// - Limit alarm maskable, overtemperature output not
// - Alarm when temperature at or below low
// - Alarm when temperature above high limit
// - Overtemperature output low above failsafe limit
// - One hysteresis value, reset ten degrees
// - Sample open-circuit comparator at conversion start
// - Shorted remote code always raises alarm
`timescale 1ns/1ps

module temp_monitor_alarm_logic #(
  parameter logic [6:0] DEVICE_ADDR       = 7'h4c,
  parameter int         CONV_INTERVAL_CYC = temp_monitor_pkg::CONV_INTERVAL_CYC
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic            alert_out,
  output logic            alert_oe_n,
  output logic            overtemp_failsafe_n_out,
  output logic            overtemp_failsafe_n_oe_n,
  input  wire logic       open_circuit_in,
  output logic            conv_start,
  output logic            conv_abort,
  input  wire logic       conv_done,
  input  wire logic [7:0] local_result,
  input  wire logic [7:0] remote_result
);

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_write,
    st_read,
    st_skip
  } bus_state_type;

  typedef struct packed {
    logic          scl_meta;
    logic          scl_sync;
    logic          scl_prev;
    logic          sda_meta;
    logic          sda_sync;
    logic          sda_prev;
    logic          open_meta;
    logic          open_sync;
    bus_state_type bus;
    logic [3:0]    bitcnt;
    logic          first;
    logic          data_phase;
    logic          ara;
    logic [7:0]    shift;
    logic [7:0]    tx;
    logic          sda_drive;
    logic [7:0]    pointer;
    logic [7:0]    config_reg;
    logic [7:0]    local_high;
    logic [7:0]    local_low;
    logic [7:0]    remote_high;
    logic [7:0]    remote_low;
    logic [7:0]    remote_overtemp_failsafe_n;
    logic [7:0]    local_overtemp_failsafe_n;
    logic [7:0]    hysteresis;
    logic [7:0]    local_temp;
    logic [7:0]    remote_temp;
    logic          open_fault;
    logic          alert_latch;
    logic          alert_drive;
    logic          ot_local;
    logic          ot_remote;
    logic          ot_drive;
    logic          busy;
    logic          single;
    logic          single_req;
    logic [31:0]   timer;
    logic          conv_start;
    logic          conv_abort;
  } state_type;

  state_type s;
  state_type next_s;

  localparam logic [31:0] TIMER_RELOAD = 32'(CONV_INTERVAL_CYC - 1);

  function automatic logic above(input logic [7:0] t, input logic [7:0] lim);
    above = $signed(t) > $signed(lim);
  endfunction : above

  // Ten bits so that limit minus a large hysteresis cannot wrap
  function automatic logic above_release(input logic [7:0] t, input logic [7:0] lim, input logic [7:0] hyst);
    logic signed [9:0] rel;
    rel = $signed({{2{lim[7]}}, lim}) - $signed({2'b00, hyst});
    above_release = $signed({{2{t[7]}}, t}) > rel;
  endfunction : above_release

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       standby;
  logic       lh;
  logic       ll;
  logic       rh;
  logic       rl;
  logic       limit_fault;
  logic       ara_done;
  logic [7:0] status;
  logic [7:0] rd_data;
  logic [7:0] load;

  always_comb begin
    scl_rise    = s.scl_sync & ~s.scl_prev;
    scl_fall    = ~s.scl_sync & s.scl_prev;
    bus_start   = s.scl_sync & s.scl_prev & s.sda_prev & ~s.sda_sync;
    bus_stop    = s.scl_sync & s.scl_prev & ~s.sda_prev & s.sda_sync;
    standby     = s.config_reg[temp_monitor_pkg::CFG_STANDBY_BIT];
    lh          = above(s.local_temp, s.local_high);
    rh          = above(s.remote_temp, s.remote_high);
    ll          = ~above(s.local_temp, s.local_low);
    rl          = ~above(s.remote_temp, s.remote_low);
    // Live compare of stored values, so limit writes in standby take effect at once
    limit_fault = lh | ll | rh | rl | s.open_fault;
    status      = 8'h00;
    status[temp_monitor_pkg::ST_BUSY]        = s.busy;
    status[temp_monitor_pkg::ST_LOCAL_HIGH]  = lh;
    status[temp_monitor_pkg::ST_LOCAL_LOW]   = ll;
    status[temp_monitor_pkg::ST_REMOTE_HIGH] = rh;
    status[temp_monitor_pkg::ST_REMOTE_LOW]  = rl;
    status[temp_monitor_pkg::ST_OPEN]        = s.open_fault;
    status[temp_monitor_pkg::ST_REMOTE_OT]   = s.ot_remote;
    status[temp_monitor_pkg::ST_LOCAL_OT]    = s.ot_local;
    unique case (s.pointer)
      temp_monitor_pkg::RD_LOCAL_TEMP:   rd_data = s.local_temp;
      temp_monitor_pkg::RD_REMOTE_TEMP:  rd_data = s.remote_temp;
      temp_monitor_pkg::RD_STATUS:       rd_data = status;
      temp_monitor_pkg::RD_CONFIG:       rd_data = s.config_reg;
      temp_monitor_pkg::RD_LOCAL_HIGH:   rd_data = s.local_high;
      temp_monitor_pkg::RD_LOCAL_LOW:    rd_data = s.local_low;
      temp_monitor_pkg::RD_REMOTE_HIGH:  rd_data = s.remote_high;
      temp_monitor_pkg::RD_REMOTE_LOW:   rd_data = s.remote_low;
      temp_monitor_pkg::RW_REMOTE_OVERTEMP_FAILSAFE_N: rd_data = s.remote_overtemp_failsafe_n;
      temp_monitor_pkg::RW_LOCAL_OVERTEMP_FAILSAFE_N:  rd_data = s.local_overtemp_failsafe_n;
      temp_monitor_pkg::RW_HYSTERESIS:   rd_data = s.hysteresis;
      default:                           rd_data = 8'hff; // Write-only or unused address
    endcase
  end

  always_comb begin
    next_s            = s;
    next_s.conv_start = 1'b0;
    next_s.conv_abort = 1'b0;
    next_s.scl_meta   = scl_in;
    next_s.scl_sync   = s.scl_meta;
    next_s.scl_prev   = s.scl_sync;
    next_s.sda_meta   = sda_in;
    next_s.sda_sync   = s.sda_meta;
    next_s.sda_prev   = s.sda_sync;
    next_s.open_meta  = open_circuit_in;
    next_s.open_sync  = s.open_meta;
    ara_done          = 1'b0;
    load              = s.ara ? {DEVICE_ADDR, 1'b1} : rd_data;

    // Conversion sequencing; timer only runs outside standby
    // Timer counts mclk cycles, so a shorter interval speeds up simulation
    // A single conversion survives standby; only periodic ones are abandoned
    if (standby || s.timer == 32'h0) begin
      next_s.timer = TIMER_RELOAD;
    end else begin
      next_s.timer = s.timer - 32'h1;
    end
    if (!s.busy && (s.single_req || (!standby && s.timer == 32'h0))) begin
      next_s.busy       = 1'b1;
      next_s.single     = s.single_req;
      next_s.single_req = 1'b0;
      next_s.conv_start = 1'b1;
      next_s.open_fault = s.open_sync;
    end else if (s.busy && standby && !s.single) begin
      next_s.busy       = 1'b0;
      next_s.conv_abort = 1'b1;
    end else if (s.busy && conv_done) begin
      next_s.busy        = 1'b0;
      next_s.single      = 1'b0;
      next_s.local_temp  = local_result;
      next_s.remote_temp = remote_result;
    end

    // Serial bus slave; runs regardless of standby
    if (bus_start) begin
      next_s.bus        = st_addr;
      next_s.bitcnt     = 4'h0;
      next_s.first      = 1'b1;
      next_s.ara        = 1'b0;
      next_s.sda_drive  = 1'b0;
    end else if (bus_stop) begin
      next_s.bus       = st_idle;
      next_s.sda_drive = 1'b0;
    end else if (s.bus != st_idle && scl_rise) begin
      if (s.bitcnt != temp_monitor_pkg::ACK_SLOT) begin
        next_s.shift = {s.shift[6:0], s.sda_sync};
        // Sent a one but line is low: another responder wins
        if (s.bus == st_read && !s.sda_drive && !s.sda_sync) begin
          next_s.bus = st_skip;
        end
      end else if (s.bus == st_read && s.sda_sync) begin
        next_s.bus = st_skip;
      end
    end else if (s.bus != st_idle && scl_fall) begin
      if (s.first) begin
        next_s.first = 1'b0;
      end else if (s.bitcnt == temp_monitor_pkg::ACK_SLOT) begin
        next_s.bitcnt    = 4'h0;
        next_s.sda_drive = 1'b0;
        if (s.bus == st_read) begin
          next_s.sda_drive = ~load[7];
          next_s.tx        = {load[6:0], 1'b0};
        end
      end else if (s.bitcnt == temp_monitor_pkg::LAST_DATA_BIT) begin
        next_s.bitcnt    = temp_monitor_pkg::ACK_SLOT;
        next_s.sda_drive = 1'b0;
        unique case (s.bus)
          st_addr: begin
            if (s.shift[7:1] == DEVICE_ADDR) begin
              next_s.sda_drive  = 1'b1;
              next_s.bus        = s.shift[0] ? st_read : st_write;
              next_s.data_phase = 1'b0;
            end else if (s.shift[7:1] == temp_monitor_pkg::ALERT_RESPONSE_ADDR && s.shift[0] && s.alert_drive) begin
              next_s.sda_drive = 1'b1;
              next_s.bus       = st_read;
              next_s.ara       = 1'b1;
            end else begin
              next_s.bus = st_skip;
            end
          end
          st_write: begin
            next_s.sda_drive  = 1'b1;
            next_s.data_phase = 1'b1;
            if (!s.data_phase) begin
              next_s.pointer = s.shift;
            end else begin
              unique case (s.pointer)
                temp_monitor_pkg::WR_CONFIG:       next_s.config_reg   = s.shift;
                temp_monitor_pkg::WR_LOCAL_HIGH:   next_s.local_high   = s.shift;
                temp_monitor_pkg::WR_LOCAL_LOW:    next_s.local_low    = s.shift;
                temp_monitor_pkg::WR_REMOTE_HIGH:  next_s.remote_high  = s.shift;
                temp_monitor_pkg::WR_REMOTE_LOW:   next_s.remote_low   = s.shift;
                temp_monitor_pkg::WR_SINGLE_CONV:  next_s.single_req   = 1'b1;
                temp_monitor_pkg::RW_REMOTE_OVERTEMP_FAILSAFE_N: next_s.remote_overtemp_failsafe_n = s.shift;
                temp_monitor_pkg::RW_LOCAL_OVERTEMP_FAILSAFE_N:  next_s.local_overtemp_failsafe_n  = s.shift;
                temp_monitor_pkg::RW_HYSTERESIS:   next_s.hysteresis   = s.shift;
                default:                           next_s.pointer      = s.pointer;
              endcase
            end
          end
          st_read: begin
            ara_done = s.ara;
          end
          st_idle,
          st_skip: begin
            next_s.sda_drive = 1'b0;
          end
        endcase
      end else begin
        next_s.bitcnt = s.bitcnt + 4'h1;
        if (s.bus == st_read) begin
          next_s.sda_drive = ~s.tx[7];
          next_s.tx        = {s.tx[6:0], 1'b0};
        end
      end
    end
    if (next_s.bus == st_skip) begin
      next_s.sda_drive = 1'b0;
    end

    // Condition keeps the latch set, so a response only clears a gone fault
    next_s.alert_latch = limit_fault | (s.alert_latch & ~ara_done);
    next_s.alert_drive = s.alert_latch & ~s.config_reg[temp_monitor_pkg::CFG_ALERT_MASK_BIT];

    // Overtemperature with shared hysteresis, never masked
    next_s.ot_local  = above(s.local_temp, s.local_overtemp_failsafe_n) |
                       (s.ot_local & above_release(s.local_temp, s.local_overtemp_failsafe_n, s.hysteresis));
    next_s.ot_remote = above(s.remote_temp, s.remote_overtemp_failsafe_n) |
                       (s.ot_remote & above_release(s.remote_temp, s.remote_overtemp_failsafe_n, s.hysteresis));
    next_s.ot_drive  = s.ot_local | s.ot_remote;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s              <= '0;
      s.scl_meta     <= 1'b1;
      s.scl_sync     <= 1'b1;
      s.scl_prev     <= 1'b1;
      s.sda_meta     <= 1'b1;
      s.sda_sync     <= 1'b1;
      s.sda_prev     <= 1'b1;
      s.bus          <= st_idle;
      s.pointer      <= temp_monitor_pkg::RST_POINTER;
      s.config_reg   <= temp_monitor_pkg::RST_CONFIG;
      s.local_high   <= temp_monitor_pkg::RST_HIGH_LIMIT;
      s.local_low    <= temp_monitor_pkg::RST_LOW_LIMIT;
      s.remote_high  <= temp_monitor_pkg::RST_HIGH_LIMIT;
      s.remote_low   <= temp_monitor_pkg::RST_LOW_LIMIT;
      s.remote_overtemp_failsafe_n <= temp_monitor_pkg::RST_OVERTEMP_FAILSAFE_N_LIMIT;
      s.local_overtemp_failsafe_n  <= temp_monitor_pkg::RST_OVERTEMP_FAILSAFE_N_LIMIT;
      s.hysteresis   <= temp_monitor_pkg::RST_HYSTERESIS;
      s.local_temp   <= temp_monitor_pkg::RST_TEMP;
      s.remote_temp  <= temp_monitor_pkg::RST_TEMP;
      s.timer        <= TIMER_RELOAD;
    end else begin
      s <= next_s;
    end
  end

  // Open-drain pins pull low only; oe_n low means driving
  assign sda_out                  = 1'b0;
  assign sda_oe_n                 = ~s.sda_drive;
  assign alert_out                = 1'b0;
  assign alert_oe_n               = ~s.alert_drive;
  assign overtemp_failsafe_n_out  = 1'b0;
  assign overtemp_failsafe_n_oe_n = ~s.ot_drive;
  assign conv_start               = s.conv_start;
  assign conv_abort               = s.conv_abort;

endmodule : temp_monitor_alarm_logic

// ===== include/temp_monitor_pkg.sv
// Constants shared by the temperature monitor control logic
package temp_monitor_pkg;

  // Register pointer values
  localparam logic [7:0] RD_LOCAL_TEMP   = 8'h00;
  localparam logic [7:0] RD_REMOTE_TEMP  = 8'h01;
  localparam logic [7:0] RD_STATUS       = 8'h02;
  localparam logic [7:0] RD_CONFIG       = 8'h03;
  localparam logic [7:0] RD_LOCAL_HIGH   = 8'h05;
  localparam logic [7:0] RD_LOCAL_LOW    = 8'h06;
  localparam logic [7:0] RD_REMOTE_HIGH  = 8'h07;
  localparam logic [7:0] RD_REMOTE_LOW   = 8'h08;
  localparam logic [7:0] WR_CONFIG       = 8'h09;
  localparam logic [7:0] WR_LOCAL_HIGH   = 8'h0b;
  localparam logic [7:0] WR_LOCAL_LOW    = 8'h0c;
  localparam logic [7:0] WR_REMOTE_HIGH  = 8'h0d;
  localparam logic [7:0] WR_REMOTE_LOW   = 8'h0e;
  localparam logic [7:0] WR_SINGLE_CONV  = 8'h0f;
  localparam logic [7:0] RW_REMOTE_OVERTEMP_FAILSAFE_N = 8'h19;
  localparam logic [7:0] RW_LOCAL_OVERTEMP_FAILSAFE_N  = 8'h20;
  localparam logic [7:0] RW_HYSTERESIS   = 8'h21;

  // Reset values
  localparam logic [7:0] RST_CONFIG      = 8'h00;
  localparam logic [7:0] RST_HIGH_LIMIT  = 8'h55;
  localparam logic [7:0] RST_LOW_LIMIT   = 8'h00;
  localparam logic [7:0] RST_OVERTEMP_FAILSAFE_N_LIMIT = 8'h55;
  localparam logic [7:0] RST_HYSTERESIS  = 8'h0a;
  localparam logic [7:0] RST_TEMP        = 8'h00;
  localparam logic [7:0] RST_POINTER     = 8'h00;

  // Configuration bit positions
  localparam int CFG_STANDBY_BIT    = 6;
  localparam int CFG_ALERT_MASK_BIT = 7;

  // Status bit positions
  localparam int ST_BUSY        = 7;
  localparam int ST_LOCAL_HIGH  = 6;
  localparam int ST_LOCAL_LOW   = 5;
  localparam int ST_REMOTE_HIGH = 4;
  localparam int ST_REMOTE_LOW  = 3;
  localparam int ST_OPEN        = 2;
  localparam int ST_REMOTE_OT   = 1;
  localparam int ST_LOCAL_OT    = 0;

  // Serial bus constants
  localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0c;
  localparam logic [3:0] ACK_SLOT            = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT       = 4'h7;

  // Conversion interval
  localparam int CONV_INTERVAL_US  = 16000;
  localparam int CLOCK_MHZ         = 250;
  localparam int CONV_INTERVAL_CYC = CONV_INTERVAL_US * CLOCK_MHZ;

endpackage : temp_monitor_pkg

// ===== bench/temp_monitor_alarm_logic_properties.sv
// Port assertions for the temperature monitor control logic
`timescale 1ns/1ps
module temp_monitor_alarm_logic_properties (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       alert_out,
  input wire logic       alert_oe_n,
  input wire logic       overtemp_failsafe_n_out,
  input wire logic       overtemp_failsafe_n_oe_n,
  input wire logic       open_circuit_in,
  input wire logic       conv_start,
  input wire logic       conv_abort,
  input wire logic       conv_done,
  input wire logic [7:0] local_result,
  input wire logic [7:0] remote_result
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too wide");
  a_abort_pulse: assert property (conv_abort |=> !conv_abort)
    else $error("abort pulse too wide");
  a_abort_no_start: assert property (conv_abort |-> !conv_start)
    else $error("abort and start together");
  // Drive may only begin after a clock fall, never inside a high phase
  a_drive_in_low: assert property ($fell(sda_oe_n) |-> !$past(scl_in))
    else $error("data drive began in clock high");
  a_drive_hold: assert property (scl_in [*6] |-> $stable(sda_oe_n))
    else $error("data drive moved in clock high");
  a_open_drain: assert property (!sda_out && !alert_out && !overtemp_failsafe_n_out)
    else $error("open-drain value not low");
  a_alert_level: assert property ($changed(alert_oe_n) |=> $stable(alert_oe_n))
    else $error("alarm toggled twice");
  a_ot_level: assert property ($changed(overtemp_failsafe_n_oe_n) |=> $stable(overtemp_failsafe_n_oe_n))
    else $error("overtemperature toggled twice");

  cover property ($fell(alert_oe_n));
  cover property ($fell(overtemp_failsafe_n_oe_n));
  cover property (conv_start ##[1:100] conv_done);
endmodule : temp_monitor_alarm_logic_properties

bind temp_monitor_alarm_logic temp_monitor_alarm_logic_properties chk_u (
  .mclk(mclk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
  .overtemp_failsafe_n_out(overtemp_failsafe_n_out), .overtemp_failsafe_n_oe_n(overtemp_failsafe_n_oe_n),
  .open_circuit_in(open_circuit_in), .conv_start(conv_start), .conv_abort(conv_abort),
  .conv_done(conv_done), .local_result(local_result), .remote_result(remote_result));

// ===== bench/smbus_host_model.sv
// Serial bus master model: 64 ns bus clock, idle high between frames
`timescale 1ns/1ps
module smbus_host_model (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // Data moves mid-low and is sampled mid-high, clear of the slave's 3-cycle lag
  task automatic xfer(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      scl <= 1'b0;
      tick(4);
      sda <= v[i];
      tick(4);
      scl <= 1'b1;
      tick(4);
      r[i] = sda_line;
      tick(4);
    end
  endtask : xfer

  task automatic start;
    tick(1);
    sda <= 1'b0;
    tick(8);
  endtask : start

  task automatic stop;
    scl <= 1'b0;
    tick(4);
    sda <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sda <= 1'b1;
    tick(8);
  endtask : stop

  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v, input logic n);
    logic [8:0] r;
    start;
    xfer({a, 2'b01}, r);
    xfer({p, 1'b1}, r);
    if (n) xfer({v, 1'b1}, r);
    stop;
  endtask : wr

  // Single byte, then no-acknowledge and stop
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic k);
    logic [8:0] r;
    start;
    xfer({a, 2'b11}, r);
    k = ~r[0];
    xfer(9'h1ff, r);
    d = r[8:1];
    stop;
  endtask : rd
endmodule : smbus_host_model

// ===== bench/testbench.sv
// Self-checking bench for the temperature monitor control logic
`timescale 1ns/1ps
module testbench;
  localparam logic [6:0] DEV = 7'h4c; // Arbitrary bus address
  localparam logic [7:0][7:0] RP = {8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h19, 8'h20, 8'h21};
  localparam logic [7:0][7:0] RV = {8'h00, 8'h55, 8'h00, 8'h55, 8'h00, 8'h55, 8'h55, 8'h0a};
  localparam logic [6:0][7:0] LT = {8'h30, 8'h31, 8'h19, 8'h00, 8'h01, 8'h19, 8'h19};
  localparam logic [6:0][7:0] RT = {8'h20, 8'h20, 8'h56, 8'h20, 8'h20, 8'h80, 8'h20};
  localparam logic [6:0][7:0] OL = {8'h60, 8'h4c, 8'h4b, 8'h19, 8'h19, 8'h19, 8'h19};
  localparam logic [6:0][7:0] TR = {8'h20, 8'h20, 8'h20, 8'h56, 8'h4b, 8'h56, 8'h55};
  localparam logic [6:0] OC = 7'b0000001;
  localparam logic [6:0] AE = 7'b0111011;
  localparam logic [6:0] OE = 7'b1101010;
  logic       mclk, resetn, scl, sda, sda_out, sda_oe_n, alert_out, alert_oe_n, ot_out, ot_oe_n;
  logic       open_c, conv_start, conv_abort, k;
  logic       conv_done = 1'b0;
  logic [7:0] loc_t, rem_t, d;
  int         fails = 0, n_tests = 0, cnt = 0, n_starts = 0, snap;
  wire logic  sda_line = sda & (sda_oe_n | sda_out);

  temp_monitor_alarm_logic #(.DEVICE_ADDR(DEV), .CONV_INTERVAL_CYC(200)) dut_u (
    .mclk(mclk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .overtemp_failsafe_n_out(ot_out), .overtemp_failsafe_n_oe_n(ot_oe_n),
    .open_circuit_in(open_c), .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_done(conv_done), .local_result(loc_t), .remote_result(rem_t));
  smbus_host_model host_u (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(sda));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Converter stand-in: results 30 cycles after a start
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    if (conv_start) begin
      cnt <= 30;
      n_starts <= n_starts + 1;
    end else if (conv_abort || cnt == 1) begin
      conv_done <= (cnt == 1) && !conv_abort;
      cnt <= 0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rreg(input logic [7:0] p);
    host_u.wr(DEV, p, 8'h00, 1'b0);
    host_u.rd(DEV, d, k);
    chk({7'h0, k}, 8'h01);
  endtask : rreg

  task automatic ara(input logic e);
    host_u.rd(7'h0c, d, k);
    chk({7'h0, k}, {7'h0, e});
    chk(d, e ? {DEV, 1'b1} : 8'hff);
    repeat (4) @(posedge mclk);
  endtask : ara

  task automatic setv(input logic [7:0] l, input logic [7:0] r, input logic o);
    loc_t <= l;
    rem_t <= r;
    open_c <= o;
  endtask : setv

  // Waits for a whole conversion started after the new inputs settled
  task automatic conv_wait;
    int i;
    int j;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 2000 && conv_start !== 1'b1; i++) @(posedge mclk);
    for (j = 0; j < 2000 && conv_done !== 1'b1; j++) @(posedge mclk);
    if (i == 2000 || j == 2000) begin
      fails++;
      $display("[ERR] %0t ns: no conversion", $time);
    end
    repeat (4) @(posedge mclk);
  endtask : conv_wait

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (80000) @(posedge mclk);
    fails++;
    report_and_stop;
  end

  initial begin
    resetn = 1'b0;
    setv(8'h19, 8'h20, 1'b0);
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int i = 7; i >= 0; i--) begin
      rreg(RP[i]);
      chk(d, RV[i]);
    end
    host_u.rd(DEV, d, k);
    chk(d, 8'h0a);
    rreg(8'h0f);
    chk(d, 8'hff);
    host_u.wr(DEV, 8'h0b, 8'h30, 1'b1);
    host_u.wr(DEV, 8'h0e, 8'h80, 1'b1);
    rreg(8'h05);
    chk(d, 8'h30);
    conv_wait;
    chk({7'h0, alert_oe_n}, 8'h00);
    ara(1'b1);
    chk({7'h0, alert_oe_n}, 8'h01);
    for (int i = 6; i >= 0; i--) begin
      setv(LT[i], RT[i], OC[i]);
      conv_wait;
      chk({7'h0, alert_oe_n}, {7'h0, ~AE[i]});
      rreg(8'h02);
      chk(d & 8'h04, {5'h0, OC[i], 2'h0});
      ara(AE[i]);
      chk({7'h0, alert_oe_n}, {7'h0, ~AE[i]});
      setv(8'h19, 8'h20, 1'b0);
      conv_wait;
      if (AE[i]) ara(1'b1);
      chk({7'h0, alert_oe_n}, 8'h01);
    end
    host_u.wr(DEV, 8'h09, 8'h80, 1'b1);
    for (int i = 6; i >= 0; i--) begin
      if (i == 1) host_u.wr(DEV, 8'h21, 8'h00, 1'b1);
      setv(OL[i], TR[i], 1'b0);
      conv_wait;
      chk({7'h0, ot_oe_n}, {7'h0, ~OE[i]});
      chk({7'h0, alert_oe_n}, 8'h01);
    end
    host_u.wr(DEV, 8'h09, 8'h00, 1'b1);
    chk({7'h0, alert_oe_n}, 8'h00);
    ara(1'b1);
    host_u.wr(DEV, 8'h09, 8'h40, 1'b1);
    repeat (300) @(posedge mclk);
    snap = n_starts;
    repeat (1000) @(posedge mclk);
    chk(8'(n_starts - snap), 8'h00);
    host_u.wr(DEV, 8'h0b, 8'h10, 1'b1);
    repeat (10) @(posedge mclk);
    chk({7'h0, alert_oe_n}, 8'h00);
    rreg(8'h05);
    chk(d, 8'h10);
    host_u.wr(DEV, 8'h0f, 8'ha5, 1'b1);
    repeat (1000) @(posedge mclk);
    chk(8'(n_starts - snap), 8'h01);
    report_and_stop;
  end
endmodule : testbench
